// *** mto_pkg.sv ***
package mto_pkg;
    localparam int CONT_W = 24;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [23:0] PCT_100 = 24'h640000;
    localparam logic [23:0] PCT_99 = 24'h630000;
    localparam logic [23:0] PCT_90 = 24'h5A0000;
    localparam logic [23:0] PCT_15 = 24'h0F0000;
    localparam logic [23:0] PCT_0 = 24'h000000;
    localparam int FRAC_SH = 16;
    localparam int Q8_SH = 8;
    localparam logic [47:0] STOP_EXP_NUM = 48'h5;
    localparam logic [47:0] MS_PER_S = 48'h3E8;
    localparam logic [47:0] HEAT_PCT = 48'h64;
    localparam logic [47:0] CURVE_MS = 48'h88B8;
    localparam logic [47:0] PCT_SCALE = 48'h64;
    localparam logic [15:0] RATIO_MAX = 16'hFFFF;
    localparam int RUN_BASE_SH = 2;
    localparam int RUN_ADD_SH = 3;
    localparam int CLK_PERIOD_NS = 25;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES_DEF = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_FLA = 8'h04;
    localparam logic [7:0] REG_SF = 8'h08;
    localparam logic [7:0] REG_CLASS = 8'h0C;
    localparam logic [7:0] REG_HC = 8'h10;
    localparam logic [7:0] REG_COOL = 8'h14;
    localparam logic [7:0] REG_STAT = 8'h18;
    localparam logic [7:0] REG_CONT = 8'h1C;
    localparam int CTRL_INDEP_BIT = 0;
    localparam int CTRL_EMER_BIT = 1;
    localparam int CTRL_FCLR_BIT = 2;
    localparam int CLASS_RUN_LSB = 8;
    localparam int STAT_ALARM_BIT = 0;
    localparam int STAT_TRIP_BIT = 1;
    localparam int STAT_LOCK_BIT = 2;
    localparam int STAT_OFF_BIT = 3;
    localparam logic [15:0] RST_FLA = 16'h0064;
    localparam logic [7:0] RST_SF = 8'h64;
    localparam logic [5:0] RST_CLASS = 6'h0A;
    localparam logic [6:0] RST_HC = 7'h3C;
    localparam logic [15:0] RST_COOL = 16'h003C;
    typedef enum logic [2:0] {
        PH_STOP, PH_KICK, PH_ACCEL, PH_PRE_UTS, PH_RUN, PH_DECEL
    } mto_phase_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } mto_bus_req_t;
    typedef struct packed {
        logic [15:0] current;
        logic [15:0] derate;
        logic [7:0] imbal_pct;
    } mto_meas_t;
    typedef struct packed {
        logic indep;
        logic [15:0] fla;
        logic [7:0] sf;
        logic [5:0] start_cls;
        logic [5:0] run_cls;
        logic [6:0] hc;
        logic [15:0] cool_s;
    } mto_cfg_t;
    typedef struct packed {
        mto_cfg_t cfg;
        logic [23:0] content;
        logic trip;
        logic lockout;
        logic alarm;
        logic [31:0] rdata;
        logic [31:0] tick_cnt;
    } mto_state_t;
endpackage

// *** mto_overload.sv ***
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ps
// What this block does
// R01 - Steady level is hot/cold ratio times current over FLA, over derate factor
// R02 - Running steady level is divided by the imbalance/harmonic derate factor
// R03 - Content below steady level rises exponentially toward it
// R04 - Content above steady level falls exponentially toward it
// R05 - Rise and fall rate come from the cooling time setting
// R06 - Separate start and run classes only when independent select is on
// R07 - Start class applies during kick, acceleration and before up-to-speed
// R08 - Run class applies at full speed and during deceleration or braking
// R09 - Changing class curves leaves accumulated content untouched
// R10 - Independent select off means run class in every phase
// R11 - Hot/cold tracking continues while the active class is off
// R12 - Active class off clamps content at 99 percent, no trip
// R13 - Both classes off forces content to zero
// R14 - Stopped content decays with exponent minus five t over cooling time
// R15 - Cooling time is the 100 to under 1 percent fall time
// R16 - Running cooling time depends on current and imbalance level
// R17 - Running cooling time is always shorter than stopped cooling time
// R18 - Emergency reset zeroes content, drops lockout, keeps the fault
// R19 - Emergency reset comes from both keys, a digital input or a control bit
// R20 - Heating accumulates above FLA times service factor at class rate
// R21 - Alarm flag when content reaches 90 percent
// R22 - Trip when content reaches 100 percent
// R23 - After trip, restart is blocked until content is below 15 percent
// R24 - Content updates on a fixed tick with fixed-point arithmetic
module mto_overload #(
    parameter int TICK_CYCLES = mto_pkg::TICK_CYCLES_DEF
) (
    // Clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic SYS_RST_IN,
    // Register port
    input wire mto_pkg::mto_bus_req_t BUS_REQ_IN,
    output logic [mto_pkg::DATA_W-1:0] RD_DATA_OUT,
    // Measurement and run state
    input wire mto_pkg::mto_meas_t MEAS_IN,
    input wire mto_pkg::mto_phase_t PHASE_IN,
    // Operator emergency reset
    input wire logic KEY_RESET_IN,
    input wire logic KEY_DOWN_IN,
    input wire logic EMER_DIN_IN,
    // Status
    output logic [mto_pkg::CONT_W-1:0] CONTENT_OUT,
    output logic ALARM_OUT,
    output logic TRIP_OUT,
    output logic LOCKOUT_OUT
);
    import mto_pkg::*;

    mto_state_t st_r;
    mto_state_t st_nxt;
    logic tick_w;
    logic emer_w;
    logic fclr_w;
    logic stopped_w;
    logic starting_w;
    logic both_off_w;
    logic cls_off_w;
    logic [5:0] cls_w;

    assign tick_w = (st_r.tick_cnt == 32'(TICK_CYCLES - 1)); // R24
    assign fclr_w = BUS_REQ_IN.wr && (BUS_REQ_IN.addr == REG_CTRL)
        && BUS_REQ_IN.wdata[CTRL_FCLR_BIT];
    assign emer_w = (KEY_RESET_IN && KEY_DOWN_IN) || EMER_DIN_IN // R19
        || (BUS_REQ_IN.wr && (BUS_REQ_IN.addr == REG_CTRL)
        && BUS_REQ_IN.wdata[CTRL_EMER_BIT]);
    assign stopped_w = (PHASE_IN == PH_STOP);
    assign starting_w = (PHASE_IN == PH_KICK) || (PHASE_IN == PH_ACCEL)
        || (PHASE_IN == PH_PRE_UTS); // R07
    // Class in force for the present phase
    assign cls_w = (st_r.cfg.indep && starting_w) ? st_r.cfg.start_cls // R06 R07 R08
        : st_r.cfg.run_cls; // R10
    assign cls_off_w = (cls_w == 6'h00);
    assign both_off_w = (st_r.cfg.start_cls == 6'h00) && (st_r.cfg.run_cls == 6'h00);

    always_comb begin
        logic [15:0] fla_g;
        logic [15:0] der_g;
        logic [15:0] cool_g;
        logic [15:0] rq;
        logic [47:0] den;
        logic [47:0] ss;
        logic [47:0] ratio;
        logic [47:0] heat;
        logic [47:0] base_ms;
        logic [47:0] tc;
        logic [47:0] mag;
        logic [47:0] step;
        logic [47:0] c48;
        logic [47:0] cap;
        logic [23:0] target;
        logic pickup;
        fla_g = 16'h0001;
        der_g = 16'h0001;
        cool_g = 16'h0001;
        rq = 16'h0000;
        den = 48'h0;
        ss = 48'h0;
        ratio = 48'h0;
        heat = 48'h0;
        base_ms = 48'h0;
        tc = 48'h1;
        mag = 48'h0;
        step = 48'h0;
        c48 = 48'h0;
        cap = 48'h0;
        target = PCT_0;
        pickup = 1'b0;
        st_nxt = st_r;
        st_nxt.rdata = 32'h0;
        st_nxt.tick_cnt = tick_w ? 32'h0 : st_r.tick_cnt + 32'h1;

        // Register writes
        if (BUS_REQ_IN.wr) begin
            case (BUS_REQ_IN.addr)
                REG_CTRL: st_nxt.cfg.indep = BUS_REQ_IN.wdata[CTRL_INDEP_BIT];
                REG_FLA: st_nxt.cfg.fla = BUS_REQ_IN.wdata[15:0];
                REG_SF: st_nxt.cfg.sf = BUS_REQ_IN.wdata[7:0];
                REG_CLASS: begin
                    st_nxt.cfg.start_cls = BUS_REQ_IN.wdata[5:0];
                    st_nxt.cfg.run_cls = BUS_REQ_IN.wdata[CLASS_RUN_LSB +: 6];
                end
                REG_HC: st_nxt.cfg.hc = BUS_REQ_IN.wdata[6:0];
                REG_COOL: st_nxt.cfg.cool_s = BUS_REQ_IN.wdata[15:0];
                default: ;
            endcase
        end

        // Register reads, data in the next cycle only
        if (BUS_REQ_IN.rd) begin
            case (BUS_REQ_IN.addr)
                REG_CTRL: st_nxt.rdata = {31'h0, st_r.cfg.indep};
                REG_FLA: st_nxt.rdata = {16'h0, st_r.cfg.fla};
                REG_SF: st_nxt.rdata = {24'h0, st_r.cfg.sf};
                REG_CLASS: st_nxt.rdata = {18'h0, st_r.cfg.run_cls, 2'h0,
                    st_r.cfg.start_cls};
                REG_HC: st_nxt.rdata = {25'h0, st_r.cfg.hc};
                REG_COOL: st_nxt.rdata = {16'h0, st_r.cfg.cool_s};
                REG_STAT: begin
                    st_nxt.rdata[STAT_ALARM_BIT] = st_r.alarm;
                    st_nxt.rdata[STAT_TRIP_BIT] = st_r.trip;
                    st_nxt.rdata[STAT_LOCK_BIT] = st_r.lockout;
                    st_nxt.rdata[STAT_OFF_BIT] = cls_off_w;
                end
                REG_CONT: st_nxt.rdata = {8'h0, st_r.content};
                default: st_nxt.rdata = 32'h0;
            endcase
        end

        // Guards against divide by zero
        fla_g = (st_r.cfg.fla == 16'h0) ? 16'h0001 : st_r.cfg.fla;
        der_g = (MEAS_IN.derate == 16'h0) ? 16'h0001 : MEAS_IN.derate;
        cool_g = (st_r.cfg.cool_s == 16'h0) ? 16'h0001 : st_r.cfg.cool_s;
        den = 48'(fla_g) * 48'(der_g);

        // Steady level in percent, 16 fraction bits
        ss = ((48'(st_r.cfg.hc) * 48'(MEAS_IN.current)) << (FRAC_SH + Q8_SH)) / den; // R01 R02
        target = stopped_w ? PCT_0 : ((ss > 48'(PCT_100)) ? PCT_100 : ss[23:0]); // R14

        // Cooling time in ms, shorter while running
        base_ms = 48'(cool_g) * MS_PER_S; // R15
        tc = base_ms;
        if (!stopped_w) begin
            tc = base_ms >> RUN_BASE_SH; // R17
            if (MEAS_IN.current > fla_g) begin
                tc = tc + (base_ms >> RUN_ADD_SH); // R16
            end
            if (MEAS_IN.imbal_pct != 8'h0) begin
                tc = tc + (base_ms >> RUN_ADD_SH); // R16
            end
        end

        // One exponential step toward the target per tick
        c48 = 48'(st_r.content);
        mag = (st_r.content > target) ? 48'(st_r.content - target)
            : 48'(target - st_r.content);
        step = (mag * STOP_EXP_NUM) / tc; // R05 R14
        if ((step == 48'h0) && (mag != 48'h0)) begin
            step = 48'h1;
        end
        if (step > mag) begin
            step = mag;
        end

        // I squared t heating above the pickup point
        ratio = (48'(MEAS_IN.current) << (FRAC_SH + Q8_SH)) / den;
        rq = (ratio > 48'(RATIO_MAX)) ? RATIO_MAX : ratio[15:0];
        pickup = (48'(MEAS_IN.current) * PCT_SCALE)
            > (48'(fla_g) * 48'(st_r.cfg.sf)); // R20
        if (pickup && !stopped_w && !cls_off_w) begin
            heat = (48'(rq) * 48'(rq) * HEAT_PCT) / (CURVE_MS * 48'(cls_w)); // R20
        end

        if (tick_w) begin
            if (st_r.content > target) begin
                c48 = c48 - step; // R04
            end else begin
                c48 = c48 + step; // R03
            end
            c48 = c48 + heat;
            cap = cls_off_w ? 48'(PCT_99) : 48'(PCT_100); // R11 R12
            st_nxt.content = (c48 > cap) ? cap[23:0] : c48[23:0]; // R24
        end
        if (both_off_w) begin
            st_nxt.content = PCT_0; // R13
        end

        // Trip, lockout and fault clear
        if (fclr_w) begin
            st_nxt.trip = 1'b0;
        end
        if (!cls_off_w && (st_nxt.content >= PCT_100)) begin
            st_nxt.trip = 1'b1; // R22
            st_nxt.lockout = 1'b1; // R23
        end else if (st_nxt.content < PCT_15) begin
            st_nxt.lockout = 1'b0; // R23
        end

        // Emergency reset keeps the fault latched
        if (emer_w) begin
            st_nxt.content = PCT_0; // R18
            st_nxt.lockout = 1'b0; // R18
        end
        st_nxt.alarm = (st_nxt.content >= PCT_90); // R21
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            st_r.cfg.indep <= 1'b0;
            st_r.cfg.fla <= RST_FLA;
            st_r.cfg.sf <= RST_SF;
            st_r.cfg.start_cls <= RST_CLASS;
            st_r.cfg.run_cls <= RST_CLASS;
            st_r.cfg.hc <= RST_HC;
            st_r.cfg.cool_s <= RST_COOL;
            st_r.content <= PCT_0;
            st_r.trip <= 1'b0;
            st_r.lockout <= 1'b0;
            st_r.alarm <= 1'b0;
            st_r.rdata <= 32'h0;
            st_r.tick_cnt <= 32'h0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign RD_DATA_OUT = st_r.rdata;
    assign CONTENT_OUT = st_r.content;
    assign ALARM_OUT = st_r.alarm;
    assign TRIP_OUT = st_r.trip;
    assign LOCKOUT_OUT = st_r.lockout;

    default clocking cb @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (SYS_RST_IN);

    a_both_off_zero: assert property ( // R13
        both_off_w |=> (st_r.content == PCT_0))
        else $error("content not zero with both classes off");
    a_class_off_clamp: assert property ( // R12
        (tick_w && cls_off_w && !both_off_w) |=> (st_r.content <= PCT_99) && !st_r.trip
            || $past(st_r.trip))
        else $error("content above 99 percent with class off");
    a_emer_clears: assert property ( // R18
        emer_w |=> (st_r.content == PCT_0) && !st_r.lockout)
        else $error("emergency reset did not clear content");
    a_emer_keeps_fault: assert property ( // R18
        (emer_w && st_r.trip && !fclr_w) |=> st_r.trip)
        else $error("emergency reset cleared the fault");
    a_trip_at_full: assert property ( // R22
        $rose(st_r.content >= PCT_100) |-> st_r.trip && st_r.lockout)
        else $error("no trip at full content");
    a_alarm_level: assert property ( // R21
        st_r.alarm == (st_r.content >= PCT_90))
        else $error("alarm flag does not match content");
    a_lockout_hold: assert property ( // R23
        (st_r.lockout && !emer_w && (st_nxt.content >= PCT_15)) |=> st_r.lockout)
        else $error("lockout released above 15 percent");
    a_stop_decay: assert property ( // R14
        (tick_w && stopped_w && !both_off_w && (st_r.content != PCT_0))
            |=> (st_r.content < $past(st_r.content)))
        else $error("content did not decay while stopped");
    a_class_seamless: assert property ( // R09
        (!tick_w && !emer_w && !both_off_w) |=> (st_r.content == $past(st_r.content)))
        else $error("content changed between ticks");
    a_read_once: assert property (
        !BUS_REQ_IN.rd |=> (RD_DATA_OUT == 32'h0))
        else $error("read data present without a read");

    c_trip_seen: cover property (!st_r.trip ##1 st_r.trip);
    c_lock_release: cover property (st_r.lockout ##1 !st_r.lockout);
    c_emer_in_lock: cover property (st_r.lockout && emer_w);
    c_start_to_run: cover property ((PHASE_IN == PH_PRE_UTS) ##1 (PHASE_IN == PH_RUN));
endmodule

// *** mto_plant.sv ***
`timescale 1ns/1ps
module mto_plant (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Settings commanded by the bench
    input wire logic [15:0] cur_in,
    input wire logic [15:0] der_in,
    input wire logic [7:0] imb_in,
    input wire mto_pkg::mto_phase_t ph_in,
    // Toward the overload block
    output mto_pkg::mto_meas_t meas_out,
    output mto_pkg::mto_phase_t phase_out
);
    import mto_pkg::*;
    // Measurement and sequencer state move one cycle after the command
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meas_out <= '0;
            phase_out <= PH_STOP;
        end else begin
            meas_out <= '{current: cur_in, derate: der_in, imbal_pct: imb_in};
            phase_out <= ph_in;
        end
    end
endmodule

// *** mto_overload_tb_top.sv ***
`timescale 1ns/1ps
module mto_overload_tb_top;
    import mto_pkg::*;
    localparam int TK = 4;
    localparam logic [31:0] SS = PCT_100 * 32'h3C / 32'h64 * 32'h32 / 32'h64;
    logic clk = 1'b0;
    logic rst = 1'b1;
    mto_bus_req_t req = '0;
    logic [31:0] rdata;
    mto_meas_t meas;
    mto_phase_t phase;
    logic [15:0] cur = 16'h0000;
    logic [15:0] der = 16'h0100;
    logic [7:0] imb = 8'h00;
    mto_phase_t ph = PH_STOP;
    logic k_rst = 1'b0;
    logic k_dn = 1'b0;
    logic din = 1'b0;
    logic [23:0] cont;
    logic alarm;
    logic trip;
    logic lock;
    int err_count = 0;
    int samples_checked = 0;
    int n;

    initial begin
        forever #12.5 clk = ~clk;
    end

    mto_plant u_mto_plant (.clk_in(clk), .rst_in(rst), .cur_in(cur), .der_in(der),
        .imb_in(imb), .ph_in(ph), .meas_out(meas), .phase_out(phase));
    mto_overload #(.TICK_CYCLES(TK)) u_mto_overload (.CLK_SYS_IN(clk), .SYS_RST_IN(rst),
        .BUS_REQ_IN(req), .RD_DATA_OUT(rdata), .MEAS_IN(meas), .PHASE_IN(phase),
        .KEY_RESET_IN(k_rst), .KEY_DOWN_IN(k_dn), .EMER_DIN_IN(din), .CONTENT_OUT(cont),
        .ALARM_OUT(alarm), .TRIP_OUT(trip), .LOCKOUT_OUT(lock));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_true(input logic c, input string what);
        samples_checked++;
        if (c !== 1'b1) begin
            err_count++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge clk);
        req <= '0;
        #1;
        chk(rdata, exp, what);
    endtask
    function automatic logic hit(input int w);
        case (w)
            0: return alarm;
            1: return trip;
            default: return !lock;
        endcase
    endfunction
    task automatic wait_for(input int w, output int k);
        k = 0;
        while (hit(w) !== 1'b1 && k < 20000) begin
            cyc(1);
            k++;
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic t_reset();
        chk({cont, alarm, trip, lock}, 32'h0, "outputs after reset");
        rd(REG_FLA, {16'h0, RST_FLA}, "fla");
        rd(REG_CLASS, {16'h0, 2'b0, RST_CLASS, 2'b0, RST_CLASS}, "class");
        rd(REG_HC, {25'h0, RST_HC}, "hot cold");
        rd(REG_COOL, {16'h0, RST_COOL}, "cool");
        rd(8'h20, 32'h0, "unmapped");
        $display("test reset done");
    endtask
    task automatic t_steady();
        wr(REG_COOL, 32'h1);
        wr(REG_CLASS, 32'h0000000A);
        cur <= 16'h0032;
        ph <= PH_RUN;
        cyc(100 * TK);
        chk_true(cont > 0 && cont < SS, "gradual rise");
        cyc(1500 * TK);
        chk(cont, SS, "steady level");
        chk(cont, SS, "no heat below pickup, tracking with class off");
        der <= 16'h0200;
        cyc(1600 * TK);
        chk(cont, SS / 2, "derated steady level");
        chk(cont, SS / 2, "settles from above");
        $display("test steady done");
    endtask
    task automatic t_clamp();
        der <= 16'h0100;
        cur <= 16'h0258;
        cyc(1500 * TK);
        chk(cont, PCT_99, "clamp");
        rd(REG_STAT, 32'h9, "status with class off");
        wr(REG_CLASS, 32'h0);
        cyc(3);
        chk(cont, PCT_0, "both off");
        cyc(50 * TK);
        chk(cont, PCT_0, "both off held");
        $display("test clamp done");
    endtask
    task automatic t_select();
        cur <= 16'h0000;
        wr(REG_CLASS, 32'h00000A00);
        wr(REG_CTRL, 32'h1);
        for (int p = 1; p < 6; p++) begin
            ph <= mto_phase_t'(p);
            cyc(4);
            rd(REG_STAT, (p < 4) ? 32'h8 : 32'h0, "class by phase");
        end
        wr(REG_CTRL, 32'h0);
        ph <= PH_ACCEL;
        cyc(4);
        rd(REG_STAT, 32'h0, "run class while starting");
        $display("test select done");
    endtask
    task automatic t_trip();
        wr(REG_CLASS, 32'h00000A0A);
        ph <= PH_RUN;
        cur <= 16'h0258;
        wait_for(0, n);
        chk_true(cont >= PCT_90 && trip === 1'b0, "alarm level");
        wait_for(1, n);
        chk(cont, PCT_100, "trip level");
        chk(lock, 1'b1, "lockout on trip");
        $display("test trip done");
    endtask
    task automatic t_cool();
        ph <= PH_STOP;
        cur <= 16'h0000;
        wait_for(2, n);
        chk_true(cont < PCT_15 && trip, "lockout release level");
        chk_true(n >= 350 * TK, "stopped decay not too fast");
        cyc(900 * TK - n);
        chk_true(cont >= 24'h010000, "above 1 percent early");
        cyc(100 * TK);
        chk_true(cont < 24'h010000, "below 1 percent at cooling time");
        wr(REG_CTRL, 32'h4);
        cyc(2);
        chk(trip, 1'b0, "fault clear");
        $display("test cool done");
    endtask
    task automatic t_emer();
        for (int m = 0; m < 3; m++) begin
            ph <= PH_RUN;
            cur <= 16'h0258;
            if (m == 0) begin
                wait_for(1, n);
            end else begin
                cyc(20 * TK);
            end
            ph <= PH_STOP;
            cur <= 16'h0000;
            cyc(2);
            chk_true(cont != 0 && trip, "content before reset");
            if (m == 0) begin
                k_rst <= 1'b1;
                k_dn <= 1'b1;
            end else if (m == 1) begin
                din <= 1'b1;
            end else begin
                wr(REG_CTRL, 32'h2);
            end
            cyc(2);
            k_rst <= 1'b0;
            k_dn <= 1'b0;
            din <= 1'b0;
            chk({cont, lock, trip}, 32'h1, "emergency reset");
        end
        $display("test emergency done");
    endtask
    task automatic t_runcool();
        wr(REG_CLASS, 32'h0000000A);
        ph <= PH_RUN;
        cur <= 16'h0258;
        cyc(1000 * TK);
        chk(cont, PCT_99, "clamped before running cool");
        cur <= 16'h0000;
        imb <= 8'h05;
        cyc(100 * TK);
        chk_true(cont > 24'h140000 && cont < 24'h280000, "running cool rate");
        $display("test running cool done");
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        cyc(1);
        t_reset();
        t_steady();
        t_clamp();
        t_select();
        t_trip();
        t_cool();
        t_emer();
        t_runcool();
        complete_run();
    end
    initial begin
        repeat (100000) @(posedge clk);
        err_count++;
        complete_run();
    end
endmodule
